// ---- pci_master_backend_port_test.sv ----
// Self-checking bench for the PCI master back-end DMA driver
`timescale 1ns/100ps
module pci_master_backend_port_test;
  logic i_clk = 0, i_rst_n = 0, i_start = 0, i_src_valid = 1, hold = 0, abt = 0;
  logic o_busy, o_done, o_error, o_src_ready, o_sink_valid, o_burst_req, o_one_left, o_two_left;
  logic o_write_direction_active, o_read_direction_active, o_outbound_word_valid, i_target_abort;
  logic o_latency_timer_enable, i_outbound_word_pop, i_write_burst_finished, i_inbound_word_push;
  logic i_read_burst_finished, i_word_moved_last_clock;
  logic [3:0] o_pci_cmd;
  logic [31:0] i_src_data = 32'h0, o_sink_data, o_master_write_address, o_master_read_address;
  logic [31:0] o_outbound_word, i_inbound_word;
  pmb_pkg::pmb_job_s i_job = '0;
  // Job rows beside the bus command each should give; addresses deliberately unaligned
  pmb_pkg::pmb_job_s rows [4] = '{'{32'h11, 16'h1, 1'b1, 4'h0}, '{32'h22, 16'h10, 1'b1, 4'hf},
    '{32'h33, 16'h2, 1'b0, 4'hc}, '{32'h41, 16'h7, 1'b0, 4'h0}};
  logic [3:0] ecmd [4] = '{4'h7, 4'hf, 4'hc, 4'h6};
  int fail_count = 0, n_checks = 0, pk = 0, sk = 0, rk = 0, cyc = 0;
  pmb_dma_driver i_pmb_dma_driver (.*);
  pmb_pci_model i_pmb_pci_model (.*);
  always #5 i_clk = ~i_clk;
  task automatic chk(input bit ok, input string m);
    n_checks++;
    if (!ok) begin
      fail_count++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask
  task automatic end_of_test();
    if (fail_count == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  always @(posedge i_clk) begin
    i_src_data <= 32'h5a00_0000 + 32'(sk);
    cyc++;
    if (cyc == 3000) begin
      fail_count++;
      end_of_test();
    end
  end
  always @(negedge i_clk) begin
    if (o_src_ready === 1'b1) sk++;
    if (i_outbound_word_pop === 1'b1) begin
      chk(o_outbound_word === 32'h5a00_0000 + 32'(pk), "wdata");
      chk(o_master_write_address === {i_job.addr[31:2], 2'h0} + 32'(4 * pk), "waddr");
      pk++;
    end
    if (o_sink_valid === 1'b1) begin
      chk(o_sink_data === 32'ha500_0000 + 32'(rk), "rdata");
      rk++;
    end
  end
  task automatic run(input pmb_pkg::pmb_job_s j, input logic [3:0] c, input logic ab);
    int r0;
    r0 = rk;
    pk = 0;
    sk = 0;
    @(posedge i_clk);
    i_job <= j;
    i_start <= 1'b1;
    hold <= 1'b1;
    abt <= ab;
    // Second start pulse lands while busy and must change nothing
    repeat (2) @(posedge i_clk) i_start <= ~i_start;
    @(posedge i_clk);
    i_start <= 1'b0;
    hold <= 1'b0;
    for (int t = 0; t < 300 && o_done !== 1'b1 && o_error !== 1'b1; t++) begin
      @(negedge i_clk);
      if (o_burst_req === 1'b1) chk(o_pci_cmd === c, "cmd");
    end
    chk((ab ? o_error : o_done) === 1'b1, "end");
    chk((j.write ? pk : rk - r0) == (ab ? 0 : int'(j.count)), "count");
  endtask
  initial begin
    repeat (8) @(posedge i_clk);
    i_rst_n <= 1'b1;
    @(negedge i_clk);
    chk(o_busy === 1'b0 && o_burst_req === 1'b0 && o_latency_timer_enable === 1'b1, "rst");
    for (int k = 0; k < 4; k++) run(rows[k], ecmd[k], 1'b0);
    run(rows[0], 4'h7, 1'b1);
    run(rows[3], 4'h6, 1'b0);
    @(posedge i_clk);
    i_job <= '0;
    i_start <= 1'b1;
    @(posedge i_clk);
    i_start <= 1'b0;
    @(negedge i_clk);
    chk(o_busy === 1'b0, "zero count");
    end_of_test();
  end
endmodule // pci_master_backend_port_test
bind pmb_dma_driver pmb_chk i_pmb_chk (.*);

// ---- pmb_chk_checker.sv ----
// Port assertions for the PCI master back-end DMA driver
`timescale 1ns/100ps
module pmb_chk (
  input wire logic i_clk, i_rst_n, o_done, o_error, o_sink_valid, o_burst_req, // Control
  input wire logic o_write_direction_active, o_read_direction_active, i_target_abort, // Modes
  input wire logic i_outbound_word_pop, i_write_burst_finished, i_read_burst_finished, // Ends
  input wire logic i_inbound_word_push, // Read strobe
  input wire logic [3:0] o_pci_cmd, // Command
  input wire logic [31:0] o_sink_data, i_inbound_word, o_master_write_address // Words
);
  wire wr = o_write_direction_active;
  wire rd = o_read_direction_active;
  wire wf = i_write_burst_finished;
  wire ab = i_target_abort;
  wire [31:0] wa = o_master_write_address;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  sequence s_end; (wr && wf || rd && i_read_burst_finished) && !ab; endsequence
  sequence s_pop; wr && i_outbound_word_pop && !wf && !ab; endsequence
  AST_ONE: assert property (!(wr && rd)) else $error("both modes");
  AST_REQ: assert property (o_burst_req == (wr || rd)) else $error("request");
  AST_HOLD: assert property (wr && !wf && !ab |=> wr) else $error("mode drop");
  AST_STEP: assert property (s_pop |=> wa == $past(wa) + 32'h4) else $error("step");
  AST_CMD: assert property (o_burst_req |=> !o_burst_req || $stable(o_pci_cmd))
    else $error("cmd moved");
  AST_SINK: assert property (i_inbound_word_push |=> o_sink_valid && o_sink_data == $past(i_inbound_word))
    else $error("sink");
  AST_DONE: assert property (s_end |-> ##1 o_done) else $error("done");
  AST_ABT: assert property (o_burst_req && ab |-> ##1 o_error) else $error("abort");
endmodule // pmb_chk

// ---- pmb_defs.svh ----
// Timing and field constants for the PCI master back-end DMA driver
`ifndef PMB_DEFS_SVH
`define PMB_DEFS_SVH
`define PMB_ADDR_STEP 32'h0000_0004
`define PMB_ADDR_LSB_ZERO 2'h0
`define PMB_CMD_MEM_READ 4'h6
`define PMB_CMD_MEM_WRITE 4'h7
`define PMB_LEFT_ONE 16'h0001
`define PMB_LEFT_TWO 16'h0002
`define PMB_BUF_DEPTH 16
`endif

// ---- pmb_dma_driver.sv ----
// DMA driver for the master back-end port of a 32-bit PCI controller
// How it works
// - Write data valid during a burst while words remain; read data always accepted.
// - Write address valid from burst start to write-done.
// - Read address valid from burst start to read-done.
// - Active address steps by four after each moved word.
// - Write direction raised at start, held until write-done.
// - Read direction raised at start, held until read-done.
// - Bus request raised once the write burst (up to DEPTH words) is preloaded, after one fill cycle for reads, held until done.
// - Last-transfer hint high when exactly one word remains.
// - Near-end hint high when two or fewer words remain.
// - Write word with valid flag; controller pop advances the store read pointer.
// - Bus command held steady while the request is high.
// - Latency timer enable always driven high.
`timescale 1ns/100ps
`include "pmb_defs.svh"
module pmb_dma_driver #(
  parameter int DEPTH = `PMB_BUF_DEPTH,
  parameter int AW = 4
) (
  input wire logic i_clk, // PCI clock
  input wire logic i_rst_n, // Sync reset, active low
  input wire logic i_start, // Start a job, one pulse
  input wire pmb_pkg::pmb_job_s i_job, // Job description
  output logic o_busy, // Job in progress
  output logic o_done, // Job finished, one pulse
  output logic o_error, // Job ended by target abort, one pulse
  input wire logic i_src_valid, // User write word available
  input wire logic [31:0] i_src_data, // User write word
  output logic o_src_ready, // Preload store accepts word
  output logic [31:0] o_sink_data, // Read word to user
  output logic o_sink_valid, // Read word strobe
  output logic [31:0] o_master_write_address, // Write address to controller
  output logic [31:0] o_master_read_address, // Read address to controller
  output logic o_write_direction_active, // Write mode
  output logic o_read_direction_active, // Read mode
  output logic o_burst_req, // Request PCI bus
  output logic [3:0] o_pci_cmd, // PCI command
  output logic o_one_left, // One word remains
  output logic o_two_left, // Two or fewer remain
  output logic [31:0] o_outbound_word, // Write data to controller
  output logic o_outbound_word_valid, // Write data valid
  output logic o_latency_timer_enable, // Honour latency timer
  input wire logic i_outbound_word_pop, // Controller took write word
  input wire logic i_write_burst_finished, // Write pipeline empty
  input wire logic [31:0] i_inbound_word, // Read data from controller
  input wire logic i_inbound_word_push, // Read data strobe
  input wire logic i_read_burst_finished, // Read pipeline empty
  input wire logic i_word_moved_last_clock, // Word moved previous clock
  input wire logic i_target_abort // Target abort seen
);
  // ==========================================================
  // State
  pmb_pkg::pmb_state_e state_q, state_d;
  pmb_pkg::pmb_job_s job_q;
  logic [15:0] left_q;
  logic [AW:0] fill_q;
  logic [AW-1:0] rd_ptr_q;
  logic [31:0] addr_q;
  logic done_q, err_q;
  logic [31:0] sink_q;
  logic sink_v_q;
  logic [31:0] mem_rdata;

  // ==========================================================
  // Decode
  // Up to DEPTH words of the burst are preloaded so the controller never sees an empty source.
  // Compare the full fill count, so a job of exactly DEPTH words is not seen as already full
  wire logic [15:0] fill_wide = 16'(fill_q);
  wire logic job_full = (fill_wide == job_q.count) || (fill_q == (AW+1)'(DEPTH));
  wire logic in_fill = (state_q == pmb_pkg::PMB_FILL);
  wire logic in_run = (state_q == pmb_pkg::PMB_RUN);
  wire logic take_src = in_fill && job_q.write && !job_full && i_src_valid;
  wire logic finished = job_q.write ? i_write_burst_finished : i_read_burst_finished;
  wire logic moved = job_q.write ? (in_run && i_outbound_word_pop) :
    (in_run && i_word_moved_last_clock);
  wire logic [3:0] cmd = (job_q.cmd != 4'h0) ? job_q.cmd :
    (job_q.write ? `PMB_CMD_MEM_WRITE : `PMB_CMD_MEM_READ);

  always_comb begin
    state_d = state_q;
    case (state_q)
      pmb_pkg::PMB_IDLE: if (i_start && i_job.count != 16'h0000) state_d = pmb_pkg::PMB_FILL;
      pmb_pkg::PMB_FILL: if (!job_q.write || job_full) state_d = pmb_pkg::PMB_RUN;
      pmb_pkg::PMB_RUN: if (finished || i_target_abort) state_d = pmb_pkg::PMB_FINISH;
      pmb_pkg::PMB_FINISH: state_d = pmb_pkg::PMB_IDLE;
      default: state_d = pmb_pkg::PMB_IDLE;
    endcase
  end

  // ==========================================================
  // Registers
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      state_q <= pmb_pkg::PMB_IDLE;
      job_q <= '0;
      left_q <= 16'h0000;
      fill_q <= '0;
      rd_ptr_q <= '0;
      addr_q <= 32'h0000_0000;
      done_q <= 1'b0;
      err_q <= 1'b0;
      sink_q <= 32'h0000_0000;
      sink_v_q <= 1'b0;
    end else begin
      state_q <= state_d;
      done_q <= in_run && finished && !i_target_abort;
      err_q <= in_run && i_target_abort;
      sink_v_q <= in_run && !job_q.write && i_inbound_word_push;
      if (i_inbound_word_push) begin
        sink_q <= i_inbound_word;
      end
      if (state_q == pmb_pkg::PMB_IDLE && i_start) begin
        job_q <= i_job;
        left_q <= i_job.count;
        addr_q <= {i_job.addr[31:2], `PMB_ADDR_LSB_ZERO};
        fill_q <= '0;
        rd_ptr_q <= '0;
      end else begin
        if (take_src) begin
          fill_q <= fill_q + 1'b1;
        end
        if (moved && left_q != 16'h0000) begin
          left_q <= left_q - 16'h0001;
          addr_q <= addr_q + `PMB_ADDR_STEP;
        end
        if (job_q.write && in_run && i_outbound_word_pop) begin
          rd_ptr_q <= rd_ptr_q + 1'b1;
        end
      end
    end
  end

  // ==========================================================
  // Outbound word store
  // Limitation: a write job longer than DEPTH words resends the stored words again after the first DEPTH.
  wire logic [AW-1:0] rd_next = (in_run && i_outbound_word_pop) ? rd_ptr_q + 1'b1 : rd_ptr_q;

  pmb_word_mem #(.DEPTH(DEPTH), .AW(AW)) u_mem (
    .i_clk(i_clk),
    .i_we(take_src),
    .i_waddr(fill_q[AW-1:0]),
    .i_wdata(i_src_data),
    .i_raddr(rd_next),
    .o_rdata(mem_rdata)
  );

  // ==========================================================
  // Outputs
  wire logic active = in_run;
  assign o_busy = (state_q != pmb_pkg::PMB_IDLE);
  assign o_done = done_q;
  assign o_error = err_q;
  assign o_src_ready = in_fill && job_q.write && !job_full;
  assign o_sink_data = sink_q;
  assign o_sink_valid = sink_v_q;
  assign o_master_write_address = addr_q;
  assign o_master_read_address = addr_q;
  assign o_write_direction_active = active && job_q.write;
  assign o_read_direction_active = active && !job_q.write;
  assign o_burst_req = active;
  assign o_pci_cmd = active ? cmd : 4'h0;
  assign o_one_left = active && (left_q == `PMB_LEFT_ONE);
  assign o_two_left = active && (left_q <= `PMB_LEFT_TWO);
  assign o_outbound_word = mem_rdata;
  assign o_outbound_word_valid = active && job_q.write && (left_q != 16'h0000);
  assign o_latency_timer_enable = 1'b1;
endmodule // pmb_dma_driver

// ---- pmb_pci_model.sv ----
// Behavioural PCI controller facing the DMA driver master port
`timescale 1ns/100ps
module pmb_pci_model (
  input wire logic i_clk, i_rst_n, hold, abt, o_one_left, o_outbound_word_valid, // Stimulus
  input wire logic o_write_direction_active, o_read_direction_active, o_burst_req, // Modes
  output logic i_outbound_word_pop, i_write_burst_finished, i_read_burst_finished, // Ends
  output logic i_inbound_word_push, i_word_moved_last_clock, i_target_abort, // Strobes
  output logic [31:0] i_inbound_word // Read word, scrambled when idle
);
  logic fin_q;
  logic [31:0] n_q;
  wire req = o_burst_req && !abt;
  // Waits while hold is high; stops only once the last word is already in flight
  wire live = req && !fin_q && !hold && !(o_one_left && i_inbound_word_push);
  wire rx = live && o_read_direction_active;
  assign i_outbound_word_pop = live && o_write_direction_active && o_outbound_word_valid;
  assign i_word_moved_last_clock = i_inbound_word_push;
  assign i_target_abort = o_burst_req && abt;
  assign i_write_burst_finished = fin_q && o_write_direction_active;
  assign i_read_burst_finished = fin_q && o_read_direction_active;
  always_ff @(posedge i_clk) begin
    fin_q <= req && (fin_q || o_one_left && (i_outbound_word_pop || i_inbound_word_push));
    i_inbound_word_push <= i_rst_n && rx;
    n_q <= i_rst_n ? n_q + 32'(rx) : 32'h0;
    i_inbound_word <= rx ? 32'ha500_0000 | n_q : ~i_inbound_word;
  end
endmodule // pmb_pci_model

// ---- pmb_pkg.sv ----
// Types shared by the PCI master back-end DMA driver
package pmb_pkg;
  typedef enum logic [1:0] {
    PMB_IDLE,
    PMB_FILL,
    PMB_RUN,
    PMB_FINISH
  } pmb_state_e;

  typedef struct packed {
    logic [31:0] addr;
    logic [15:0] count;
    logic write;
    logic [3:0] cmd;
  } pmb_job_s;

  typedef struct packed {
    logic one_left;
    logic two_left;
  } pmb_hint_s;
endpackage

// ---- pmb_word_mem.sv ----
// Small word store that holds the outgoing data of one DMA burst
`timescale 1ns/100ps
module pmb_word_mem #(
  parameter int DEPTH = 16,
  parameter int AW = 4
) (
  input wire logic i_clk, // Clock
  input wire logic i_we, // Write strobe
  input wire logic [AW-1:0] i_waddr, // Write index
  input wire logic [31:0] i_wdata, // Write word
  input wire logic [AW-1:0] i_raddr, // Read index
  output logic [31:0] o_rdata // Registered read word
);
  logic [31:0] mem_q [DEPTH];

  always_ff @(posedge i_clk) begin
    if (i_we) begin
      mem_q[i_waddr] <= i_wdata;
    end
    o_rdata <= mem_q[i_raddr];
  end
endmodule // pmb_word_mem
